/* hps_debounce.sv */
// Debouncer: two-flop synchroniser and stable-level counter
`timescale 1ns/100ps
module hps_debounce #(
   parameter int unsigned STABLE_CYC = 320000
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic raw_in,
   input wire logic reset_value,
   output logic clean_out
);
   logic sync1_reg;
   logic sync2_reg;
   logic [hps_pkg::CNT_W-1:0] cnt_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sync1_reg <= reset_value;
         sync2_reg <= reset_value;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Counter restarts whenever the level matches the accepted one
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cnt_reg <= '0;
         clean_out <= reset_value;
      end else if (sync2_reg == clean_out) begin
         cnt_reg <= '0;
      end else if (cnt_reg >= hps_pkg::CNT_W'(STABLE_CYC - 1)) begin
         cnt_reg <= '0;
         clean_out <= sync2_reg;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule : hps_debounce

/* hps_host_model.sv */
// Host processor model driving the hold request
`timescale 1ns/100ps
module hps_host_model (
   input wire logic clk_sys,
   input wire logic host_reset_n,
   input wire logic ans,
   input wire logic drop,
   input wire logic [6:0] rdly,
   output logic host_hold_request
);
   logic [7:0] wait_reg;
   initial begin
      host_hold_request = 1'b0;
      wait_reg = 8'h00;
   end
   always @(posedge clk_sys) begin
      if (host_reset_n !== 1'b1 || drop) begin
         wait_reg <= #10 8'h00;
         host_hold_request <= #10 1'b0;
      end else if (ans) begin
         wait_reg <= #10 wait_reg + 8'h01;
         if (wait_reg == {1'b0, rdly}) host_hold_request <= #10 1'b1;
      end
   end
endmodule : hps_host_model

/* hps_pkg.sv */
// Package of constants for the handset power-up sequencer
package hps_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   // Times as printed, in their own units
   localparam int unsigned DEBOUNCE_MS = 32;
   localparam int unsigned RESET_DELAY_MS = 20;
   localparam int unsigned REG_DELAY_STD_US = 125;
   localparam int unsigned REG_DELAY_OPT_MS = 10;
   localparam int unsigned HOLD_TIMEOUT_MS = 500;
   // Derived cycle counts at the system clock
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned REG_DELAY_STD_CYC = REG_DELAY_STD_US * (CLK_HZ / 1_000_000);
   localparam int unsigned REG_DELAY_OPT_CYC = REG_DELAY_OPT_MS * (CLK_HZ / 1000);
   localparam int unsigned HOLD_TIMEOUT_CYC = HOLD_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 24;
   // Flag comparators: thresholds in percent of target output
   localparam logic [6:0] FLAG_RISE_PCT = 7'd95;
   localparam logic [6:0] FLAG_FALL_PCT = 7'd90;
   typedef enum logic [2:0] {
      HPS_OFF = 3'b000,
      HPS_FIRST_UP = 3'b001,
      HPS_SECOND_UP = 3'b010,
      HPS_RESET_WAIT = 3'b011,
      HPS_HOLD_WAIT = 3'b100,
      HPS_RUN = 3'b101,
      HPS_DOWN_SECOND = 3'b110,
      HPS_DOWN_FIRST = 3'b111
   } hps_state_t;
endpackage : hps_pkg

/* hps_sequencer.sv */
// Handset power-up and power-down sequencer
`timescale 1ns/100ps
// Function
// - Regulator error flags stay internal; no port shows them.
// - Each flag rises when its output reaches the 95 percent threshold.
// - Each flag falls at the 90 percent threshold, giving hysteresis.
// - Key and external-power inputs are debounced 32 ms before use.
// - Host reset released 20 ms after second flag rises.
// - Second regulator disabled 20 ms after host reset goes low.
// - Second regulator enabled 125 us after first flag rises.
// - First regulator disabled one regulator delay after second flag falls.
// - Optional variant uses a 10 ms regulator delay instead.
// - Time from reset release until hold rises; window 500 ms.
// - Hold timeout clears interrupt, asserts reset, powers down; else clear interrupt. With external power, code keeps reset released and stays powered.
// - Debounced key press asserts interrupt and enables first regulator.
// - External power active keeps regulators on despite hold low.
module hps_sequencer #(
   parameter int unsigned DEBOUNCE_CYC = hps_pkg::DEBOUNCE_CYC,
   parameter int unsigned RESET_DELAY_CYC = hps_pkg::RESET_DELAY_CYC,
   parameter int unsigned REG_DELAY_OPT_CYC = hps_pkg::REG_DELAY_OPT_CYC,
   parameter int unsigned HOLD_TIMEOUT_CYC = hps_pkg::HOLD_TIMEOUT_CYC,
   parameter bit LONG_REG_DELAY = 1'b0
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic key_wake_input,
   input wire logic ext_power_detect_n,
   input wire logic host_hold_request,
   input wire logic [6:0] first_regulator_pct,
   input wire logic [6:0] second_regulator_pct,
   output logic first_regulator_en,
   output logic second_regulator_en,
   output logic host_reset_n,
   output logic host_irq_n
);
   localparam int unsigned REG_CYC = LONG_REG_DELAY ? REG_DELAY_OPT_CYC : hps_pkg::REG_DELAY_STD_CYC;

   hps_pkg::hps_state_t state_reg;
   hps_pkg::hps_state_t state_next;
   logic [hps_pkg::CNT_W-1:0] timer_reg;
   logic timer_clear;
   logic key_db;
   logic ext_db;
   logic key_db_d_reg;
   logic hold_s1_reg;
   logic hold_reg;
   logic first_flag_reg;
   logic second_flag_reg;
   logic irq_reg;

   function automatic logic flag_next(input logic cur, input logic [6:0] pct);
      if (pct >= hps_pkg::FLAG_RISE_PCT) begin
         flag_next = 1'b1;
      end else if (pct <= hps_pkg::FLAG_FALL_PCT) begin
         flag_next = 1'b0;
      end else begin
         flag_next = cur;
      end
   endfunction : flag_next

   function automatic logic timer_done(input logic [hps_pkg::CNT_W-1:0] t, input int unsigned lim);
      timer_done = (t >= hps_pkg::CNT_W'(lim - 1));
   endfunction : timer_done

   // Debounced key and external-power levels
   hps_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_key_db (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .raw_in(key_wake_input),
      .reset_value(1'b0),
      .clean_out(key_db)
   );
   // Active-level form of the detect: high means external power present
   hps_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_ext_db (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .raw_in(~ext_power_detect_n),
      .reset_value(1'b0),
      .clean_out(ext_db)
   );

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         hold_s1_reg <= 1'b0;
         hold_reg <= 1'b0;
         key_db_d_reg <= 1'b0;
      end else begin
         hold_s1_reg <= host_hold_request;
         hold_reg <= hold_s1_reg;
         key_db_d_reg <= key_db;
      end
   end

   // Internal error flags with hysteresis, never brought to a port
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         first_flag_reg <= 1'b0;
         second_flag_reg <= 1'b0;
      end else begin
         first_flag_reg <= flag_next(first_flag_reg, first_regulator_pct);
         second_flag_reg <= flag_next(second_flag_reg, second_regulator_pct);
      end
   end

   logic key_press;
   assign key_press = key_db & ~key_db_d_reg;

   always_comb begin
      state_next = state_reg;
      timer_clear = 1'b0;
      case (state_reg)
         hps_pkg::HPS_OFF: begin
            timer_clear = 1'b1;
            if (key_press || ext_db) begin
               state_next = hps_pkg::HPS_FIRST_UP;
            end
         end
         hps_pkg::HPS_FIRST_UP: begin
            timer_clear = ~first_flag_reg;
            if (first_flag_reg && timer_done(timer_reg, REG_CYC)) begin
               state_next = hps_pkg::HPS_SECOND_UP;
               timer_clear = 1'b1;
            end
         end
         hps_pkg::HPS_SECOND_UP: begin
            timer_clear = ~second_flag_reg;
            if (second_flag_reg && timer_done(timer_reg, RESET_DELAY_CYC)) begin
               state_next = hps_pkg::HPS_HOLD_WAIT;
               timer_clear = 1'b1;
            end
         end
         hps_pkg::HPS_HOLD_WAIT: begin
            if (hold_reg) begin
               state_next = hps_pkg::HPS_RUN;
            end else if (timer_done(timer_reg, HOLD_TIMEOUT_CYC)) begin
               if (ext_db) begin
                  state_next = hps_pkg::HPS_RUN;
               end else begin
                  state_next = hps_pkg::HPS_DOWN_SECOND;
                  timer_clear = 1'b1;
               end
            end
         end
         hps_pkg::HPS_RUN: begin
            timer_clear = 1'b1;
            if (!hold_reg && !ext_db) begin
               state_next = hps_pkg::HPS_DOWN_SECOND;
            end
         end
         hps_pkg::HPS_DOWN_SECOND: begin
            if (timer_done(timer_reg, RESET_DELAY_CYC)) begin
               state_next = hps_pkg::HPS_DOWN_FIRST;
               timer_clear = 1'b1;
            end
         end
         hps_pkg::HPS_DOWN_FIRST: begin
            timer_clear = second_flag_reg;
            if (!second_flag_reg && timer_done(timer_reg, REG_CYC)) begin
               state_next = hps_pkg::HPS_OFF;
            end
         end
         default: begin
            state_next = hps_pkg::HPS_OFF;
            timer_clear = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_reg <= hps_pkg::HPS_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // Shared timer, restarted on each state change or lost condition
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         timer_reg <= '0;
      end else if (timer_clear || state_next != state_reg) begin
         timer_reg <= '0;
      end else if (timer_reg != '1) begin
         timer_reg <= timer_reg + 1'b1;
      end
   end

   // Interrupt: set on a debounced key press, cleared at end of hold wait
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         irq_reg <= 1'b0;
      end else if (key_press) begin
         irq_reg <= 1'b1;
      end else if (state_reg == hps_pkg::HPS_HOLD_WAIT && state_next != hps_pkg::HPS_HOLD_WAIT) begin
         irq_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         first_regulator_en <= 1'b0;
         second_regulator_en <= 1'b0;
         host_reset_n <= 1'b0;
         host_irq_n <= 1'b1;
      end else begin
         first_regulator_en <= (state_next != hps_pkg::HPS_OFF);
         second_regulator_en <= (state_next == hps_pkg::HPS_SECOND_UP) || (state_next == hps_pkg::HPS_HOLD_WAIT)
            || (state_next == hps_pkg::HPS_RUN) || (state_next == hps_pkg::HPS_DOWN_SECOND);
         host_reset_n <= (state_next == hps_pkg::HPS_HOLD_WAIT) || (state_next == hps_pkg::HPS_RUN);
         host_irq_n <= ~irq_reg;
      end
   end
endmodule : hps_sequencer

/* hps_sequencer_asserts.sv */
// Port checks for the power sequencer
`timescale 1ns/100ps
module hps_sequencer_asserts #(
   parameter int unsigned RESET_DELAY_CYC = 30,
   parameter int unsigned REG_CYC = 1250
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic host_hold_request,
   input wire logic [6:0] first_regulator_pct,
   input wire logic [6:0] second_regulator_pct,
   input wire logic first_regulator_en,
   input wire logic second_regulator_en,
   input wire logic host_reset_n,
   input wire logic host_irq_n
);
   logic [15:0] c1_reg, c2_reg, d2_reg;
   // Cycles spent above or below each threshold
   always_ff @(posedge clk_sys) c1_reg <= first_regulator_pct < 7'h5f ? 16'h0 : c1_reg + 16'h1;
   always_ff @(posedge clk_sys) c2_reg <= second_regulator_pct < 7'h5f ? 16'h0 : c2_reg + 16'h1;
   always_ff @(posedge clk_sys) d2_reg <= second_regulator_pct > 7'h5a ? 16'h0 : d2_reg + 16'h1;
   sequence s_second_held;
      second_regulator_en [*8];
   endsequence
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   reset_idle_a: assert property (disable iff (1'b0) !rst_b |=> !first_regulator_en && !host_reset_n && host_irq_n)
      else $error("outputs not idle in reset");
   enable_order_a: assert property (second_regulator_en |-> first_regulator_en)
      else $error("second on without first");
   reset_order_a: assert property (host_reset_n |-> second_regulator_en)
      else $error("reset released without second");
   second_delay_a: assert property ($rose(second_regulator_en) |-> c1_reg inside {[REG_CYC-4:REG_CYC+8]})
      else $error("second enable delay wrong");
   release_delay_a: assert property ($rose(host_reset_n) |-> c2_reg inside {[RESET_DELAY_CYC:RESET_DELAY_CYC+8]})
      else $error("reset release delay wrong");
   second_held_a: assert property ($fell(host_reset_n) |-> s_second_held)
      else $error("second dropped too soon");
   first_off_a: assert property ($fell(first_regulator_en) |-> d2_reg inside {[REG_CYC-4:REG_CYC+8]})
      else $error("first disable delay wrong");
   irq_clear_a: assert property ($rose(host_hold_request) && host_reset_n && !host_irq_n |-> ##[1:6] host_irq_n)
      else $error("irq not cleared by hold");
endmodule : hps_sequencer_asserts
bind hps_sequencer hps_sequencer_asserts #(.RESET_DELAY_CYC(RESET_DELAY_CYC), .REG_CYC(REG_CYC)) chk (.clk_sys(clk_sys),
   .rst_b(rst_b), .host_hold_request(host_hold_request), .first_regulator_pct(first_regulator_pct),
   .second_regulator_pct(second_regulator_pct), .first_regulator_en(first_regulator_en),
   .second_regulator_en(second_regulator_en), .host_reset_n(host_reset_n), .host_irq_n(host_irq_n));

/* hps_sequencer_tb.sv */
// Self-checking bench for the power sequencer
`timescale 1ns/100ps
module hps_sequencer_tb;
   localparam int DEB = 20;
   localparam int RDLY = 30;
   localparam int HOLD = 100;
   localparam int REG = 1250;
   localparam int REGO = 15;
   logic clk_sys, rst_b, key_wake_input, ext_power_detect_n, ans, drop, host_hold_request;
   logic first_regulator_en, second_regulator_en, host_reset_n, host_irq_n;
   logic long_first_en, long_second_en, long_reset_n, long_irq_n;
   logic [6:0] first_regulator_pct, second_regulator_pct, rdly;
   int err_count, samples_checked, seed, n, m;
   hps_sequencer #(.DEBOUNCE_CYC(DEB), .RESET_DELAY_CYC(RDLY), .HOLD_TIMEOUT_CYC(HOLD)) uut (.clk_sys(clk_sys),
      .rst_b(rst_b), .key_wake_input(key_wake_input), .ext_power_detect_n(ext_power_detect_n),
      .host_hold_request(host_hold_request), .first_regulator_pct(first_regulator_pct),
      .second_regulator_pct(second_regulator_pct), .first_regulator_en(first_regulator_en),
      .second_regulator_en(second_regulator_en), .host_reset_n(host_reset_n), .host_irq_n(host_irq_n));
   // Optional regulator delay variant (15 cycles, shorter than the standard 1250) on the same stimulus
   hps_sequencer #(.DEBOUNCE_CYC(DEB), .RESET_DELAY_CYC(RDLY), .REG_DELAY_OPT_CYC(REGO), .HOLD_TIMEOUT_CYC(HOLD),
      .LONG_REG_DELAY(1'b1)) uut_long (.clk_sys(clk_sys), .rst_b(rst_b), .key_wake_input(key_wake_input),
      .ext_power_detect_n(ext_power_detect_n), .host_hold_request(host_hold_request),
      .first_regulator_pct(first_regulator_pct), .second_regulator_pct(second_regulator_pct),
      .first_regulator_en(long_first_en), .second_regulator_en(long_second_en), .host_reset_n(long_reset_n),
      .host_irq_n(long_irq_n));
   hps_host_model host (.clk_sys(clk_sys), .host_reset_n(host_reset_n), .ans(ans), .drop(drop), .rdly(rdly),
      .host_hold_request(host_hold_request));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Regulator outputs follow their enables a cycle late
   always @(posedge clk_sys) begin
      first_regulator_pct <= #10 first_regulator_en ? 7'h5f + 7'($unsigned($random(seed)) % 33) : 7'h0;
      second_regulator_pct <= #10 second_regulator_en ? 7'h5f : 7'h0;
   end
   function automatic logic in_win(input int seen, input int lo, input int hi);
      return seen >= lo && seen <= hi;
   endfunction : in_win
   task automatic tick();
      @(posedge clk_sys);
      #10;
   endtask : tick
   task automatic check(input string name, input logic exp, input logic seen);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %b seen %b", name, exp, seen);
      end
   endtask : check
   task automatic wait_on(ref logic sig, input logic want, input int lim);
      n = 0;
      while (sig !== want && n < lim) begin
         tick();
         n++;
      end
   endtask : wait_on
   task automatic power_up(input logic by_key);
      tick();
      if (by_key) key_wake_input = 1'b1;
      else ext_power_detect_n = 1'b0;
      wait_on(first_regulator_en, 1'b1, DEB + 20);
      check("start_delay", 1'b1, in_win(n, DEB, DEB + 8));
      tick();
      check("irq_on_key", ~by_key, host_irq_n);
      check("irq_opt", ~by_key, long_irq_n);
      key_wake_input = 1'b0;
      wait_on(long_second_en, 1'b1, REG + 20);
      check("reg_delay_opt", 1'b1, in_win(n, REGO, REGO + 8));
      m = n;
      wait_on(second_regulator_en, 1'b1, REG + 20);
      check("reg_delay", 1'b1, in_win(n + m, REG, REG + 8));
      wait_on(host_reset_n, 1'b1, RDLY + 20);
      check("reset_delay", 1'b1, in_win(n, RDLY, RDLY + 8));
      check("reset_opt", 1'b1, long_reset_n);
   endtask : power_up
   task automatic power_down(input int lo, input int hi);
      wait_on(host_reset_n, 1'b0, hi + 4);
      check("reset_low", 1'b1, in_win(n, lo, hi));
      check("reset_low_opt", 1'b0, long_reset_n);
      wait_on(second_regulator_en, 1'b0, RDLY + 20);
      check("second_off", 1'b1, in_win(n, RDLY, RDLY + 4));
      wait_on(long_first_en, 1'b0, REG + 20);
      check("first_off_opt", 1'b1, in_win(n, REGO, REGO + 8));
      m = n;
      wait_on(first_regulator_en, 1'b0, REG + 20);
      check("first_off", 1'b1, in_win(n + m, REG, REG + 8));
   endtask : power_down
   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      test_done();
   end
   initial begin
      seed = 38964;
      {rst_b, key_wake_input, ans, drop} = 4'h0;
      ext_power_detect_n = 1'b1;
      first_regulator_pct = 7'h0;
      second_regulator_pct = 7'h0;
      rdly = 7'h1 + 7'($unsigned($random(seed)) % 60);
      repeat (2) tick();
      rst_b = 1'b1;
      key_wake_input = 1'b1;
      repeat (DEB - 6) tick();
      key_wake_input = 1'b0;
      wait_on(first_regulator_en, 1'b1, DEB + 20);
      check("glitch", 1'b0, first_regulator_en);
      ans = 1'b1;
      power_up(1'b1);
      wait_on(host_irq_n, 1'b1, HOLD);
      check("irq_clear", 1'b1, in_win(n, rdly, rdly + 8));
      repeat (HOLD) tick();
      check("stay_on", 1'b1, host_reset_n);
      drop = 1'b1;
      power_down(1, 6);
      {ans, drop} = 2'h0;
      power_up(1'b1);
      power_down(HOLD, HOLD + 8);
      check("irq_off", 1'b1, host_irq_n);
      power_up(1'b0);
      repeat (HOLD + 20) tick();
      check("ext_keep", 1'b1, host_reset_n);
      ext_power_detect_n = 1'b1;
      power_down(DEB, DEB + 8);
      test_done();
   end
endmodule : hps_sequencer_tb
